// file: src/mpp_pkg.sv
package mpp_pkg;
	// Flat pin vector: group 0, 1, 2, 4 then 14
	localparam int NPIN    = 20;
	localparam int G0_LSB  = 0;
	localparam int G1_LSB  = 5;
	localparam int G2_LSB  = 11;
	localparam int G4_LSB  = 16;
	localparam int G14_LSB = 19;
	localparam int DBG_BIT = 16;
	localparam int T7_BIT  = 17;
	localparam int T4_BIT  = 18;

	// Register offsets
	localparam logic [7:0] A_LAT0  = 8'h00;
	localparam logic [7:0] A_LAT1  = 8'h01;
	localparam logic [7:0] A_LAT2  = 8'h02;
	localparam logic [7:0] A_LAT4  = 8'h04;
	localparam logic [7:0] A_LAT12 = 8'h0C;
	localparam logic [7:0] A_LAT13 = 8'h0D;
	localparam logic [7:0] A_LAT14 = 8'h0E;
	localparam logic [7:0] A_LAT15 = 8'h0F;
	localparam logic [7:0] A_DIR0  = 8'h20;
	localparam logic [7:0] A_DIR1  = 8'h21;
	localparam logic [7:0] A_DIR2  = 8'h22;
	localparam logic [7:0] A_DIR4  = 8'h24;
	localparam logic [7:0] A_DIR14 = 8'h2E;
	localparam logic [7:0] A_PU0   = 8'h30;
	localparam logic [7:0] A_PU1   = 8'h31;
	localparam logic [7:0] A_PU4   = 8'h34;
	localparam logic [7:0] A_GROUP14_PULLUP_REG  = 8'h3E;
	localparam logic [7:0] A_TTL0  = 8'h40;
	localparam logic [7:0] A_OD0   = 8'h50;
	localparam logic [7:0] A_OD1   = 8'h51;
	localparam logic [7:0] A_ANA0  = 8'h60;
	localparam logic [7:0] A_ANA1  = 8'h61;
	localparam logic [7:0] A_ANA4  = 8'h64;
	localparam logic [7:0] A_CONVERTER_PIN_CONFIG_REG  = 8'h70;
	localparam logic [7:0] A_REDIR = 8'h77;
	localparam logic [7:0] A_EDGR  = 8'h78;
	localparam logic [7:0] A_EDGF  = 8'h79;
	localparam logic [7:0] A_CLKM  = 8'h7A;

	// Implemented-bit masks
	localparam logic [4:0] TTL0_MASK = 5'h1B;
	localparam logic [4:0] OD0_MASK  = 5'h1C;
	localparam logic [4:0] ANA0_MASK = 5'h0C;
	localparam logic [2:0] ANA4_MASK = 3'h2;

	// Reset values, flat vectors
	localparam logic [NPIN-1:0] DIR_RST = 20'hFFFFF;
	localparam logic [NPIN-1:0] LAT_RST = 20'h00000;
	localparam logic [NPIN-1:0] ANA_RST = 20'h2FFEC;
	localparam logic [NPIN-1:0] PU_RST  = 20'h00000;

	// Pins able to pull up: groups 0, 1, 4, 14
	localparam logic [NPIN-1:0] PU_CAP  = 20'hF07FF;
endpackage : mpp_pkg

// file: src/mpp_port_pins.sv
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module mpp_port_pins (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// Register port
	input  wire logic [7:0]                 reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output      logic [7:0]                 reg_rdata,
	// Bidirectional port pins, groups 0,1,2,4,14
	input  wire logic [mpp_pkg::NPIN-1:0]   pin_in,
	output      logic [mpp_pkg::NPIN-1:0]   pin_out,
	output      logic [mpp_pkg::NPIN-1:0]   pin_oe,
	output      logic [mpp_pkg::NPIN-1:0]   pin_pullup_en,
	output      logic [mpp_pkg::NPIN-1:0]   pin_analog_sel,
	output      logic [4:0]                 grp0_ttl_sel,
	// Fixed-direction pins
	input  wire logic                       grp12_pin_one,
	input  wire logic                       grp12_pin_two,
	output      logic                       main_clk_pin_sel,
	output      logic                       grp13_output_pin,
	input  wire logic                       grp13_input_pin,
	// Timer side
	output      logic                       timer4_count_input,
	output      logic                       timer7_count_input,
	input  wire logic                       timer4_output,
	input  wire logic                       timer7_output,
	// Debugger side
	input  wire logic                       debug_en,
	input  wire logic                       debug_data_out,
	input  wire logic                       debug_data_oe,
	output      logic                       debug_data_in,
	// Other peripherals
	input  wire logic                       buzzer_out,
	output      logic                       ext_irq_zero,
	output      logic                       ext_irq_grp14,
	output      logic [7:0]                 key_return_in
);
	import mpp_pkg::*;

	//////////////////////////////////////////////////////////////////////
	// Storage
	logic [NPIN-1:0] lat_r;
	logic [NPIN-1:0] dir_r;
	logic [NPIN-1:0] pu_r;
	logic [NPIN-1:0] ana_r;
	logic [4:0]      ttl_r;
	logic [10:0]     od_r;
	logic            lat13_r;
	logic            redir_r;
	logic [1:0]      edg_rise_r;
	logic [1:0]      edg_fall_r;
	logic            clkm_r;
	logic [NPIN-1:0] sy1_r;
	logic [NPIN-1:0] sy2_r;
	logic [2:0]      fx1_r;
	logic [2:0]      fx2_r;
	logic [1:0]      irq_prev_r;
	logic [1:0]      irq_r;
	logic [7:0]      rdata_r;

	//////////////////////////////////////////////////////////////////////
	// Write decode
	wire wr_lat0  = reg_wr && reg_addr == A_LAT0;
	wire wr_lat1  = reg_wr && reg_addr == A_LAT1;
	wire wr_lat2  = reg_wr && reg_addr == A_LAT2;
	wire wr_lat4  = reg_wr && reg_addr == A_LAT4;
	wire wr_lat13 = reg_wr && reg_addr == A_LAT13;
	wire wr_lat14 = reg_wr && reg_addr == A_LAT14;
	wire wr_dir0  = reg_wr && reg_addr == A_DIR0;
	wire wr_dir1  = reg_wr && reg_addr == A_DIR1;
	wire wr_dir2  = reg_wr && reg_addr == A_DIR2;
	wire wr_dir4  = reg_wr && reg_addr == A_DIR4;
	wire wr_dir14 = reg_wr && reg_addr == A_DIR14;
	wire wr_pu0   = reg_wr && reg_addr == A_PU0;
	wire wr_pu1   = reg_wr && reg_addr == A_PU1;
	wire wr_pu4   = reg_wr && reg_addr == A_PU4;
	wire wr_group14_pullup_reg  = reg_wr && reg_addr == A_GROUP14_PULLUP_REG;
	wire wr_ttl0  = reg_wr && reg_addr == A_TTL0;
	wire wr_od0   = reg_wr && reg_addr == A_OD0;
	wire wr_od1   = reg_wr && reg_addr == A_OD1;
	wire wr_ana0  = reg_wr && reg_addr == A_ANA0;
	wire wr_ana1  = reg_wr && reg_addr == A_ANA1;
	wire wr_ana4  = reg_wr && reg_addr == A_ANA4;
	wire wr_converter_pin_config_reg  = reg_wr && reg_addr == A_CONVERTER_PIN_CONFIG_REG;
	wire wr_redir = reg_wr && reg_addr == A_REDIR;
	wire wr_edgr  = reg_wr && reg_addr == A_EDGR;
	wire wr_edgf  = reg_wr && reg_addr == A_EDGF;
	wire wr_clkm  = reg_wr && reg_addr == A_CLKM;
	// Group 15 offset decodes to nothing: writes dropped, reads zero

	//////////////////////////////////////////////////////////////////////
	// Latches and direction
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lat_r   <= LAT_RST;
			dir_r   <= DIR_RST;
			lat13_r <= 1'b0;
		end else begin
			if (wr_lat0)  lat_r[G0_LSB +: 5]  <= reg_wdata[4:0];
			if (wr_lat1)  lat_r[G1_LSB +: 6]  <= reg_wdata[5:0];
			if (wr_lat2)  lat_r[G2_LSB +: 5]  <= reg_wdata[4:0];
			if (wr_lat4)  lat_r[G4_LSB +: 3]  <= reg_wdata[2:0];
			if (wr_lat14) lat_r[G14_LSB]      <= reg_wdata[0];
			if (wr_lat13) lat13_r             <= reg_wdata[0];
			if (wr_dir0)  dir_r[G0_LSB +: 5]  <= reg_wdata[4:0];
			if (wr_dir1)  dir_r[G1_LSB +: 6]  <= reg_wdata[5:0];
			if (wr_dir2)  dir_r[G2_LSB +: 5]  <= reg_wdata[4:0];
			if (wr_dir4)  dir_r[G4_LSB +: 3]  <= reg_wdata[2:0];
			if (wr_dir14) dir_r[G14_LSB]      <= reg_wdata[0];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Pad options
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pu_r  <= PU_RST;
			ana_r <= ANA_RST;
			ttl_r <= 5'h00;
			od_r  <= 11'h000;
		end else begin
			if (wr_pu0)  pu_r[G0_LSB +: 5] <= reg_wdata[4:0];
			if (wr_pu1)  pu_r[G1_LSB +: 6] <= reg_wdata[5:0];
			if (wr_pu4)  pu_r[G4_LSB +: 3] <= reg_wdata[2:0];
			if (wr_group14_pullup_reg) pu_r[G14_LSB]     <= reg_wdata[0];
			if (wr_ttl0) ttl_r <= reg_wdata[4:0] & TTL0_MASK;
			if (wr_od0)  od_r[4:0] <= reg_wdata[4:0] & OD0_MASK;
			if (wr_od1)  od_r[10:5] <= reg_wdata[5:0];
			if (wr_ana0)
				ana_r[G0_LSB +: 5] <= reg_wdata[4:0] & ANA0_MASK;
			if (wr_ana1) ana_r[G1_LSB +: 6] <= reg_wdata[5:0];
			if (wr_ana4)
				ana_r[G4_LSB +: 3] <= reg_wdata[2:0] & ANA4_MASK;
			if (wr_converter_pin_config_reg) ana_r[G2_LSB +: 5] <= reg_wdata[4:0];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Routing and interrupt configuration
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			redir_r    <= 1'b0;
			edg_rise_r <= 2'h0;
			edg_fall_r <= 2'h0;
			clkm_r     <= 1'b0;
		end else begin
			if (wr_redir) redir_r    <= reg_wdata[0];
			if (wr_edgr)  edg_rise_r <= reg_wdata[1:0];
			if (wr_edgf)  edg_fall_r <= reg_wdata[1:0];
			if (wr_clkm)  clkm_r     <= reg_wdata[0];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Input synchronisers; first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sy1_r <= '0;
			sy2_r <= '0;
			fx1_r <= 3'h0;
			fx2_r <= 3'h0;
		end else begin
			sy1_r <= pin_in;
			sy2_r <= sy1_r;
			fx1_r <= {grp13_input_pin, grp12_pin_two, grp12_pin_one};
			fx2_r <= fx1_r;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Pad drive
	// Debugger owns its pin outright while enabled
	wire dbg_own = debug_en;
	// Timer and buzzer outputs OR onto the latch, so the latch must be 0
	wire [NPIN-1:0] alt_out = {buzzer_out, timer4_output,
		timer7_output, {(NPIN-3){1'b0}}};
	wire [NPIN-1:0] drive   = lat_r | alt_out;
	wire [NPIN-1:0] od_full = {{(NPIN-11){1'b0}}, od_r};
	wire [NPIN-1:0] is_out  = ~dir_r & ~ana_r;
	// Open drain: drive low only, release for a one
	wire [NPIN-1:0] oe_port = is_out & (~od_full | ~drive);
	wire [NPIN-1:0] out_port = drive & ~od_full;
	wire [NPIN-1:0] dbg_mask = {{(NPIN-DBG_BIT-1){1'b0}}, dbg_own,
		{DBG_BIT{1'b0}}};

	assign pin_out = (out_port & ~dbg_mask)
		| ({NPIN{debug_data_out}} & dbg_mask);
	assign pin_oe  = (oe_port & ~dbg_mask)
		| ({NPIN{debug_data_oe}} & dbg_mask);
	assign pin_pullup_en = pu_r & PU_CAP & dir_r & ~ana_r
		& ~dbg_mask;
	assign pin_analog_sel = ana_r;
	assign grp0_ttl_sel   = ttl_r;
	assign main_clk_pin_sel = clkm_r;
	assign grp13_output_pin = lat13_r;

	//////////////////////////////////////////////////////////////////////
	// Digital inputs
	// Gate analog pins so reads stay quiet with the pad floating
	wire [NPIN-1:0] dig_in = sy2_r & ~ana_r;
	wire [NPIN-1:0] rd_vec = (dir_r & dig_in) | (~dir_r & lat_r);
	// Resonator on group 12 reads back as zero
	wire [1:0] g12_rd = clkm_r ? 2'h0 : fx2_r[1:0];

	assign timer4_count_input = dig_in[T4_BIT];
	assign timer7_count_input = dig_in[T7_BIT];
	assign debug_data_in      = sy2_r[DBG_BIT];
	assign key_return_in = redir_r
		? {sy2_r[G2_LSB+2 +: 3] & ~ana_r[G2_LSB+2 +: 3],
		   dig_in[G0_LSB +: 5]}
		: {2'h0, dig_in[G1_LSB +: 6]};

	//////////////////////////////////////////////////////////////////////
	// External interrupts: bit 0 from group 13, bit 1 from group 14
	wire [1:0] irq_lvl  = {dig_in[G14_LSB], fx2_r[2]};
	wire [1:0] irq_rise = irq_lvl & ~irq_prev_r;
	wire [1:0] irq_fall = ~irq_lvl & irq_prev_r;
	wire [1:0] irq_hit  = (irq_rise & edg_rise_r)
		| (irq_fall & edg_fall_r);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_prev_r <= 2'h0;
			irq_r      <= 2'h0;
		end else begin
			irq_prev_r <= irq_lvl;
			irq_r      <= irq_hit;
		end
	end

	assign ext_irq_zero  = irq_r[0];
	assign ext_irq_grp14 = irq_r[1];

	//////////////////////////////////////////////////////////////////////
	// Read path; unmapped offsets read zero
	wire [7:0] rd_mux =
		reg_addr == A_LAT0  ? {3'h0, rd_vec[G0_LSB +: 5]} :
		reg_addr == A_LAT1  ? {2'h0, rd_vec[G1_LSB +: 6]} :
		reg_addr == A_LAT2  ? {3'h0, rd_vec[G2_LSB +: 5]} :
		reg_addr == A_LAT4  ? {5'h00, rd_vec[G4_LSB +: 3]} :
		reg_addr == A_LAT12 ? {5'h00, g12_rd, 1'b0} :
		reg_addr == A_LAT13 ? {fx2_r[2], 6'h00, lat13_r} :
		reg_addr == A_LAT14 ? {7'h00, rd_vec[G14_LSB]} :
		reg_addr == A_DIR0  ? {3'h0, dir_r[G0_LSB +: 5]} :
		reg_addr == A_DIR1  ? {2'h0, dir_r[G1_LSB +: 6]} :
		reg_addr == A_DIR2  ? {3'h0, dir_r[G2_LSB +: 5]} :
		reg_addr == A_DIR4  ? {5'h00, dir_r[G4_LSB +: 3]} :
		reg_addr == A_DIR14 ? {7'h00, dir_r[G14_LSB]} :
		reg_addr == A_PU0   ? {3'h0, pu_r[G0_LSB +: 5]} :
		reg_addr == A_PU1   ? {2'h0, pu_r[G1_LSB +: 6]} :
		reg_addr == A_PU4   ? {5'h00, pu_r[G4_LSB +: 3]} :
		reg_addr == A_GROUP14_PULLUP_REG  ? {7'h00, pu_r[G14_LSB]} :
		reg_addr == A_TTL0  ? {3'h0, ttl_r} :
		reg_addr == A_OD0   ? {3'h0, od_r[4:0]} :
		reg_addr == A_OD1   ? {2'h0, od_r[10:5]} :
		reg_addr == A_ANA0  ? {3'h0, ana_r[G0_LSB +: 5]} :
		reg_addr == A_ANA1  ? {2'h0, ana_r[G1_LSB +: 6]} :
		reg_addr == A_ANA4  ? {5'h00, ana_r[G4_LSB +: 3]} :
		reg_addr == A_CONVERTER_PIN_CONFIG_REG  ? {3'h0, ana_r[G2_LSB +: 5]} :
		reg_addr == A_REDIR ? {7'h00, redir_r} :
		reg_addr == A_EDGR  ? {6'h00, edg_rise_r} :
		reg_addr == A_EDGF  ? {6'h00, edg_fall_r} :
		reg_addr == A_CLKM  ? {7'h00, clkm_r} :
		8'h00;

	always_ff @(posedge clk) begin
		if (!rst_n)
			rdata_r <= 8'h00;
		else if (reg_rd)
			rdata_r <= rd_mux;
		else
			rdata_r <= 8'h00;
	end

	assign reg_rdata = rdata_r;
endmodule : mpp_port_pins

// file: test/mpp_port_pins_assertions.sv
`timescale 1ns/1ns
module mpp_port_pins_chk
	import mpp_pkg::*;
(
	// Clock and reset
	input wire logic            clk,
	input wire logic            rst_n,
	// Register port
	input wire logic            reg_rd,
	input wire logic [7:0]      reg_rdata,
	// Pads
	input wire logic [NPIN-1:0] pin_in,
	input wire logic [NPIN-1:0] pin_out,
	input wire logic [NPIN-1:0] pin_oe,
	input wire logic [NPIN-1:0] pin_pullup_en,
	input wire logic [NPIN-1:0] pin_analog_sel,
	// Peripheral side
	input wire logic            grp13_input_pin,
	input wire logic            ext_irq_zero,
	input wire logic            timer4_count_input,
	input wire logic            timer4_output,
	input wire logic            debug_en,
	input wire logic            debug_data_oe,
	input wire logic            buzzer_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside a read cycle");
	a_analog_undriven: assert property (
		(pin_oe & pin_analog_sel & ~(20'h1 << DBG_BIT)) == 20'h00000)
		else $error("analog pad is driven");
	a_pullup_input: assert property (
		(pin_pullup_en & pin_oe) == 20'h00000)
		else $error("pull-up on a driven pad");
	a_pullup_capable: assert property (
		(pin_pullup_en & ~PU_CAP) == 20'h00000)
		else $error("pull-up on a pad without one");
	a_irq_edge_cause: assert property (ext_irq_zero |->
		$past(grp13_input_pin, 3) != $past(grp13_input_pin, 4))
		else $error("irq pulse without a pin edge");
	a_debug_owns_pin: assert property (
		debug_en |-> pin_oe[DBG_BIT] == debug_data_oe)
		else $error("debug pin enable wrong");
	a_timer_in_sync: assert property ($past(rst_n) && $past(rst_n, 2) |->
		timer4_count_input == $past(pin_in[T4_BIT], 2))
		else $error("timer input not two cycles behind pad");
	a_timer_out_drive: assert property (
		timer4_output && pin_oe[T4_BIT] |-> pin_out[T4_BIT])
		else $error("timer output missing on pad");
	a_buzzer_drive: assert property (
		buzzer_out && pin_oe[G14_LSB] |-> pin_out[G14_LSB])
		else $error("buzzer missing on pad");
	a_reset_inputs: assert property (
		!$past(rst_n) && !debug_en |-> pin_oe == 20'h00000)
		else $error("pad driven right after reset");
endmodule : mpp_port_pins_chk

bind mpp_port_pins mpp_port_pins_chk u_chk (.clk(clk), .rst_n(rst_n),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
	.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
	.pin_analog_sel(pin_analog_sel), .grp13_input_pin(grp13_input_pin),
	.ext_irq_zero(ext_irq_zero), .timer4_count_input(timer4_count_input),
	.timer4_output(timer4_output), .debug_en(debug_en),
	.debug_data_oe(debug_data_oe), .buzzer_out(buzzer_out));

// file: test/mpp_pad_model.sv
`timescale 1ns/1ns
module mpp_pad_model
	import mpp_pkg::*;
(
	// Clock
	input wire logic            clk,
	// Device pad side
	input wire logic [NPIN-1:0] pin_out,
	input wire logic [NPIN-1:0] pin_oe,
	input wire logic [NPIN-1:0] pin_pullup_en,
	// Board side
	input wire logic [NPIN-1:0] ext_val,
	input wire logic [NPIN-1:0] ext_drv,
	output     logic [NPIN-1:0] pin_in
);
	// Floating pads wander so a stale level never reads as valid
	logic [NPIN-1:0] float_r = 20'h5A5A5;
	wire  [NPIN-1:0] free_w  = ~pin_oe & ~ext_drv;
	always_ff @(posedge clk) float_r <= ~float_r;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
		| (free_w & pin_pullup_en) | (free_w & ~pin_pullup_en & float_r);
endmodule : mpp_pad_model

// file: test/test_multiplexed_port_pins.sv
`timescale 1ns/1ns
module test_multiplexed_port_pins;
	import mpp_pkg::*;
	logic            clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0]      reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [NPIN-1:0] ext_val = 20'h00000, ext_drv = 20'hFFFFF;
	logic            g12a = 1'b0, g12b = 1'b0, g13_in = 1'b0, t4o = 1'b0;
	logic            t7o = 1'b0, dbg_en = 1'b0, dbg_do = 1'b0, dbg_oe = 1'b0;
	logic            buzz = 1'b0;
	logic [7:0]      reg_rdata, key;
	logic [NPIN-1:0] pin_in, pin_out, pin_oe, pin_pu, pin_ana;
	logic [4:0]      ttl;
	logic            clk_sel, g13_out, t4i, t7i, dbg_di, irq0, irq14;
	int              n_errors = 0, checks_done = 0, cyc = 0, n_irq = 0;
	int              n_irq14 = 0;

	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (irq0 === 1'b1) n_irq++;
		if (irq14 === 1'b1) n_irq14++;
		if (cyc == 5000) begin
			n_errors++;
			final_report();
		end
	end

	mpp_port_pins dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pullup_en(pin_pu), .pin_analog_sel(pin_ana),
		.grp0_ttl_sel(ttl), .grp12_pin_one(g12a), .grp12_pin_two(g12b),
		.main_clk_pin_sel(clk_sel), .grp13_output_pin(g13_out),
		.grp13_input_pin(g13_in), .timer4_count_input(t4i),
		.timer7_count_input(t7i), .timer4_output(t4o), .timer7_output(t7o),
		.debug_en(dbg_en), .debug_data_out(dbg_do), .debug_data_oe(dbg_oe),
		.debug_data_in(dbg_di), .buzzer_out(buzz), .ext_irq_zero(irq0),
		.ext_irq_grp14(irq14), .key_return_in(key));
	mpp_pad_model board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup_en(pin_pu), .ext_val(ext_val), .ext_drv(ext_drv),
		.pin_in(pin_in));

	task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd
	// Two sync stages plus one edge of margin
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	task automatic tick;
		@(posedge clk);
	endtask : tick
	//////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(A_DIR0, 8'h1F);
		rd(A_DIR1, 8'h3F);
		rd(A_DIR4, 8'h07);
		rd(A_DIR14, 8'h01);
		chk(pin_ana, ANA_RST);
		chk(pin_oe, 20'h00000);
	endtask : t_reset
	task automatic t_masks;
		wr(A_TTL0, 8'hFF);
		rd(A_TTL0, 8'h1B);
		chk(ttl, 5'h1B);
		wr(A_OD0, 8'hFF);
		rd(A_OD0, 8'h1C);
		wr(A_OD0, 8'h00);
		wr(A_LAT15, 8'hFF);
		rd(A_LAT15, 8'h00);
		rd(8'h90, 8'h00);
	endtask : t_masks
	task automatic t_port0;
		wr(A_DIR0, 8'h00);
		chk(pin_oe[4:0], 5'h13);
		wr(A_LAT0, 8'h13);
		chk(pin_out[4:0] & 5'h13, 5'h13);
		rd(A_LAT0, 8'h13);
		wr(A_DIR0, 8'h1F);
		ext_val[4:0] <= 5'h1D;
		settle();
		rd(A_LAT0, 8'h11);
		// Open drain on bit 4: a latched one releases the pad
		wr(A_DIR0, 8'h00);
		wr(A_OD0, 8'h10);
		chk(pin_oe[4:0], 5'h03);
		wr(A_LAT0, 8'h00);
		chk({pin_oe[4:0], pin_out[4:0]}, 10'h260);
		wr(A_DIR0, 8'h1F);
		wr(A_OD0, 8'h00);
	endtask : t_port0
	task automatic t_grp14;
		wr(A_GROUP14_PULLUP_REG, 8'h01);
		chk(pin_pu[G14_LSB], 1'b1);
		wr(A_DIR14, 8'h00);
		chk(pin_pu[G14_LSB], 1'b0);
		buzz <= 1'b1;
		tick();
		#1;
		chk(pin_out[G14_LSB] & pin_oe[G14_LSB], 1'b1);
		buzz <= 1'b0;
		settle();
		wr(A_EDGR, 8'h02);
		n_irq14 = 0;
		buzz <= 1'b1;
		repeat (6) tick();
		#1;
		chk(n_irq14, 1);
		wr(A_EDGR, 8'h00);
	endtask : t_grp14
	task automatic t_grp13;
		logic [2:0] r;
		logic [2:0] f;
		logic [1:0] n [3];
		r = 3'b101;
		f = 3'b110;
		n = '{2'd1, 2'd1, 2'd2};
		wr(A_LAT13, 8'h01);
		chk(g13_out, 1'b1);
		g13_in <= 1'b1;
		settle();
		rd(A_LAT13, 8'h81);
		g13_in <= 1'b0;
		settle();
		for (int i = 0; i < 3; i++) begin
			wr(A_EDGR, {7'h00, r[i]});
			wr(A_EDGF, {7'h00, f[i]});
			n_irq = 0;
			g13_in <= 1'b1;
			repeat (6) tick();
			g13_in <= 1'b0;
			repeat (6) tick();
			#1;
			chk(n_irq, n[i]);
		end
	endtask : t_grp13
	task automatic t_timer;
		wr(A_ANA4, 8'h00);
		wr(A_DIR4, 8'h03);
		t4o <= 1'b1;
		ext_val[T7_BIT] <= 1'b1;
		settle();
		chk(pin_out[T4_BIT] & pin_oe[T4_BIT], 1'b1);
		chk({t4i, t7i}, 2'b11);
		t7o <= 1'b1;
		wr(A_DIR4, 8'h01);
		chk(pin_out[T7_BIT] & pin_oe[T7_BIT], 1'b1);
		wr(A_DIR4, 8'h03);
		wr(A_ANA4, 8'h02);
		settle();
		chk(t7i, 1'b0);
	endtask : t_timer
	task automatic t_debug;
		dbg_en <= 1'b1;
		dbg_oe <= 1'b1;
		tick();
		#1;
		chk({pin_oe[DBG_BIT], pin_out[DBG_BIT]}, 2'b10);
		dbg_oe <= 1'b0;
		ext_val[DBG_BIT] <= 1'b1;
		settle();
		chk(dbg_di, 1'b1);
	endtask : t_debug
	task automatic t_analog_redir;
		wr(A_CONVERTER_PIN_CONFIG_REG, 8'h1F);
		chk(pin_ana[15:11], 5'h1F);
		wr(A_CONVERTER_PIN_CONFIG_REG, 8'h00);
		chk(pin_ana[15:11], 5'h00);
		wr(A_ANA1, 8'h00);
		chk(pin_ana[10:5], 6'h00);
		wr(A_ANA0, 8'h00);
		ext_val[15:0] <= 16'hA2B5;
		settle();
		chk(key, 8'h15);
		wr(A_REDIR, 8'h01);
		chk(key, 8'hB5);
	endtask : t_analog_redir
	task automatic t_grp12;
		g12a <= 1'b1;
		g12b <= 1'b1;
		settle();
		rd(A_LAT12, 8'h06);
		wr(A_LAT12, 8'h00);
		rd(A_LAT12, 8'h06);
		wr(A_CLKM, 8'h01);
		chk(clk_sel, 1'b1);
		rd(A_LAT12, 8'h00);
		dbg_en <= 1'b0;
		rst_n <= 1'b0;
		repeat (2) tick();
		rst_n <= 1'b1;
		rd(A_DIR4, 8'h07);
		chk(clk_sel, 1'b0);
	endtask : t_grp12
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report
	//////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) tick();
		rst_n <= 1'b1;
		t_reset();
		t_masks();
		t_port0();
		t_grp14();
		t_grp13();
		t_timer();
		t_debug();
		t_analog_redir();
		t_grp12();
		final_report();
	end
endmodule : test_multiplexed_port_pins
